// File: rtl/ssd_pkg.sv
package ssd_pkg;

  localparam int unsigned ACC_W       = 16;
  localparam int unsigned CNT_W       = 16;
  localparam logic [15:0] ACC_RESET   = 16'h0000;
  localparam logic [15:0] ACC_POS_MAX = 16'h7fff;
  localparam logic [15:0] ACC_NEG_MAX = 16'h8000;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  // modulus counter prescale choices
  localparam int unsigned MC_DIV_LO   = 64;
  localparam int unsigned MC_DIV_HI   = 512;
  // sample prescale = SAMPLE_DIV_BASE << sample_rate_sel
  localparam int unsigned SAMPLE_DIV_BASE = 8;
  localparam int unsigned PRE_W       = 9;
  localparam logic [1:0]  STEP_LAST   = 2'h3;
  localparam logic [1:0]  STEP_FIRST  = 2'h0;

  // coil modes from {integrate_select, drive_coil_select}
  typedef enum logic [3:0] {
    SSD_BLANK_NODRV = 4'h1,
    SSD_BLANK_DRV   = 4'h2,
    SSD_CONVERT     = 4'h4,
    SSD_INTEGRATE   = 4'h8
  } ssd_mode_t;

  // per-bridge drive: 00 open, 01 drive positive, 10 drive negative, 11 recirculate
  typedef enum logic [1:0] {
    SSD_BR_OPEN = 2'h0,
    SSD_BR_POS  = 2'h1,
    SSD_BR_NEG  = 2'h2,
    SSD_BR_RECIRCULATE_SELECT = 2'h3
  } ssd_bridge_t;

  typedef struct packed {
    logic       integrate_select;
    logic       drive_coil_select;
    logic       return_zero_enable;
    logic       counter_clockwise;
    logic       step_advance;
    logic [1:0] sample_rate_sel;
    logic       converter_power_up;
    logic       wait_powerdown;
    logic       mc_div_sel;
    logic       modulus_mode;
  } ssd_ctrl_t;

  typedef struct packed {
    ssd_bridge_t sin_bridge;
    ssd_bridge_t cos_bridge;
    logic        sin_to_converter;
    logic        cos_to_converter;
    logic        converter_reset;
    logic        converter_on;
    logic        offset_comp;
  } ssd_drive_t;

endpackage : ssd_pkg

// File: rtl/ssd_stall_detector.sv
`timescale 1ns/1ps
module ssd_stall_detector
  import ssd_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // control
  input  wire ssd_pkg::ssd_ctrl_t ctrl,
  input  wire logic              stop_mode,
  input  wire logic              wait_mode,
  // modulus counter load
  input  wire logic              cnt_write,
  input  wire logic [15:0]       cnt_wdata,
  input  wire logic              cnt_force_load,
  input  wire logic              underflow_clear,
  input  wire logic              overflow_clear,
  // converter bit stream, from the analog side
  input  wire logic              sd_bit,
  // status
  output logic [15:0]            accumulator,
  output logic [15:0]            count,
  output logic [1:0]             step_index,
  output logic                   counter_underflow_flag,
  output logic                   accumulator_overflow_flag,
  // bridge drive
  output ssd_pkg::ssd_drive_t    drive
);
  import ssd_pkg::*;

  typedef struct packed {
    logic [1:0]  sd_sync;
    logic        sd_last;
    logic [15:0] acc;
    logic [15:0] load;
    logic [15:0] cnt;
    logic [PRE_W-1:0] mc_pre;
    logic [PRE_W-1:0] smp_pre;
    logic [1:0]  step;
    logic        uf;
    logic        ov;
    logic        adv_last;
    logic        cnt_timing;
    ssd_drive_t  drv;
  } ssd_state_t;

  ssd_state_t s_q;
  ssd_state_t s_d;
  ssd_mode_t  mode;
  logic       sd_stable;
  logic       sleep;
  logic       mc_tick;
  logic       smp_tick;
  logic [PRE_W-1:0] mc_top;
  logic [PRE_W-1:0] smp_top;
  logic [16:0] acc_sum;
  // set events of this cycle, so a clear in the same cycle cannot hide them
  logic        uf_set;
  logic        ov_set;

  always_comb
  begin
    unique case ({ctrl.integrate_select, ctrl.drive_coil_select})
      2'b00:   mode = SSD_BLANK_NODRV;
      2'b01:   mode = SSD_BLANK_DRV;
      2'b10:   mode = SSD_CONVERT;
      default: mode = SSD_INTEGRATE;
    endcase
  end

  assign sleep     = stop_mode | (wait_mode & ctrl.wait_powerdown);
  assign mc_top    = ctrl.mc_div_sel ? PRE_W'(MC_DIV_HI - 1) : PRE_W'(MC_DIV_LO - 1);
  assign smp_top   = PRE_W'((SAMPLE_DIV_BASE << ctrl.sample_rate_sel) - 1);
  assign mc_tick   = (s_q.mc_pre == mc_top);
  assign smp_tick  = (s_q.smp_pre == smp_top);
  // second and third stage must agree before the bit counts
  assign sd_stable = (s_q.sd_sync[1] == s_q.sd_last);

  always_comb
  begin
    s_d = s_q;
    uf_set = 1'b0;
    ov_set = 1'b0;
    s_d.sd_sync = {s_q.sd_sync[0], sd_bit};
    s_d.sd_last = s_q.sd_sync[1];

    // step sequencing on a rising advance request
    s_d.adv_last = ctrl.step_advance;
    if (ctrl.step_advance && !s_q.adv_last)
    begin
      if (ctrl.counter_clockwise)
        s_d.step = (s_q.step == STEP_LAST) ? STEP_FIRST : s_q.step + 2'h1;
      else
        s_d.step = (s_q.step == STEP_FIRST) ? STEP_LAST : s_q.step - 2'h1;
    end

    // modulus counter: prescaler frozen while asleep
    if (!sleep)
      s_d.mc_pre = mc_tick ? '0 : s_q.mc_pre + PRE_W'(1);
    if (mc_tick && !sleep && s_q.cnt != CNT_ZERO)
    begin
      s_d.cnt = s_q.cnt - 16'h0001;
      if (s_q.cnt == 16'h0001)
      begin
        s_d.uf = 1'b1;
        uf_set = 1'b1;
        if (ctrl.modulus_mode)
          s_d.cnt = s_q.load;
      end
    end
    if (cnt_write)
    begin
      s_d.load = cnt_wdata;
      // a zero write parks the counter without raising the flag
      if (!ctrl.modulus_mode || cnt_wdata == CNT_ZERO)
        s_d.cnt = cnt_wdata;
    end
    if (cnt_force_load)
      s_d.cnt = s_q.load;
    if (underflow_clear && !uf_set)
      s_d.uf = 1'b0;
    s_d.cnt_timing = (s_d.cnt != CNT_ZERO);

    // accumulator; sample clock held at zero in blanking so a rate change waits
    s_d.smp_pre = (smp_tick || !ctrl.integrate_select) ? '0 : s_q.smp_pre + PRE_W'(1);
    acc_sum = {s_q.acc[15], s_q.acc} + (s_q.sd_last ? 17'h00001 : 17'h1ffff);
    if (!ctrl.integrate_select)
      s_d.acc = ACC_RESET;
    else if (smp_tick && sd_stable && ctrl.converter_power_up && !sleep)
    begin
      if (acc_sum[16] != acc_sum[15])
      begin
        s_d.acc = acc_sum[16] ? ACC_NEG_MAX : ACC_POS_MAX;
        s_d.ov  = 1'b1;
        ov_set  = 1'b1;
      end
      else
        s_d.acc = acc_sum[15:0];
    end
    if (overflow_clear && !ov_set)
      s_d.ov = 1'b0;

    // bridge set-up: step bit 0 picks which coil is measured
    s_d.drv.converter_reset  = !ctrl.integrate_select;
    s_d.drv.converter_on     = ctrl.converter_power_up && !sleep;
    s_d.drv.offset_comp      = (mode == SSD_INTEGRATE) && s_q.cnt_timing;
    s_d.drv.sin_to_converter = ctrl.integrate_select && !s_d.step[0];
    s_d.drv.cos_to_converter = ctrl.integrate_select && s_d.step[0];
    s_d.drv.sin_bridge = SSD_BR_OPEN;
    s_d.drv.cos_bridge = SSD_BR_OPEN;
    if (ctrl.return_zero_enable)
    begin
      unique case (mode)
        SSD_BLANK_NODRV:
        begin
          if (s_d.step[0]) s_d.drv.cos_bridge = SSD_BR_RECIRCULATE_SELECT;
          else             s_d.drv.sin_bridge = SSD_BR_RECIRCULATE_SELECT;
        end
        SSD_BLANK_DRV, SSD_INTEGRATE:
        begin
          // four full-step states, driven coil polarity from step
          if (s_d.step[0])
          begin
            s_d.drv.sin_bridge = s_d.step[1] ? SSD_BR_NEG : SSD_BR_POS;
            if (mode == SSD_BLANK_DRV) s_d.drv.cos_bridge = SSD_BR_RECIRCULATE_SELECT;
          end
          else
          begin
            s_d.drv.cos_bridge = s_d.step[1] ? SSD_BR_NEG : SSD_BR_POS;
            if (mode == SSD_BLANK_DRV) s_d.drv.sin_bridge = SSD_BR_RECIRCULATE_SELECT;
          end
        end
        SSD_CONVERT: ;
      endcase
      // stop or wait powerdown recirculates both coils
      if (sleep)
      begin
        s_d.drv.sin_bridge = SSD_BR_RECIRCULATE_SELECT;
        s_d.drv.cos_bridge = SSD_BR_RECIRCULATE_SELECT;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.drv.converter_reset <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign accumulator               = s_q.acc;
  assign count                     = s_q.cnt;
  assign step_index                = s_q.step;
  assign counter_underflow_flag    = s_q.uf;
  assign accumulator_overflow_flag = s_q.ov;
  assign drive                     = s_q.drv;

  acc_blank_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl.integrate_select |=> accumulator == ACC_RESET && drive.converter_reset)
    else $error("accumulator not cleared in blanking");
  acc_sat_a: assert property (@(posedge clk) disable iff (rst)
    $past(accumulator) == ACC_POS_MAX && accumulator != ACC_POS_MAX |-> accumulator != ACC_NEG_MAX)
    else $error("accumulator wrapped past positive limit");
  acc_negsat_a: assert property (@(posedge clk) disable iff (rst)
    $past(accumulator) == ACC_NEG_MAX && accumulator != ACC_NEG_MAX |-> accumulator != ACC_POS_MAX)
    else $error("accumulator wrapped past negative limit");
  step_ccw_a: assert property (@(posedge clk) disable iff (rst)
    ctrl.step_advance && !s_q.adv_last && ctrl.counter_clockwise |=> step_index == $past(step_index) + 2'h1)
    else $error("ccw step wrong");
  step_cw_a: assert property (@(posedge clk) disable iff (rst)
    ctrl.step_advance && !s_q.adv_last && !ctrl.counter_clockwise |=> step_index == $past(step_index) - 2'h1)
    else $error("cw step wrong");
  sleep_pwr_a: assert property (@(posedge clk) disable iff (rst)
    stop_mode |=> !drive.converter_on)
    else $error("converter on in stop");
  wait_pwr_a: assert property (@(posedge clk) disable iff (rst)
    wait_mode && ctrl.wait_powerdown && !cnt_write && !cnt_force_load |=> count == $past(count))
    else $error("counter ran during wait powerdown");
  pwrup_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl.converter_power_up |=> !drive.converter_on)
    else $error("converter on with power-up clear");
  uf_set_a: assert property (@(posedge clk) disable iff (rst)
    mc_tick && !sleep && count == 16'h0001 |=> counter_underflow_flag)
    else $error("underflow flag not set");
  conv_open_a: assert property (@(posedge clk) disable iff (rst)
    mode == SSD_CONVERT && ctrl.return_zero_enable && !sleep
      |=> drive.sin_bridge == SSD_BR_OPEN && drive.cos_bridge == SSD_BR_OPEN)
    else $error("coils driven in conversion");

endmodule : ssd_stall_detector

// File: verification/ssd_coil_model.sv
`timescale 1ns/1ps
module ssd_coil_model
  import ssd_pkg::*;
(
  // bus side
  input  wire logic                clk,
  input  wire ssd_pkg::ssd_drive_t drive,
  input  wire logic                emf_pos,
  // converter bit stream
  output logic                     sd_bit
);
  logic flip_q = 1'b0;
  // an unrouted coil has no steady back emf, so the stream toggles
  always_ff @(posedge clk)
  begin
    flip_q <= ~flip_q;
    sd_bit <= (drive.sin_to_converter | drive.cos_to_converter) ? emf_pos : flip_q;
  end
endmodule : ssd_coil_model

// File: verification/ssd_stall_detector_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module ssd_stall_detector_bench;
  import ssd_pkg::*;
  logic clk = 0, rst = 1, stop_mode = 0, wait_mode = 0, cnt_write = 0, cnt_force_load = 0;
  logic underflow_clear = 0, overflow_clear = 0, sd_bit, emf_pos = 1, uf, ov;
  logic [15:0] cnt_wdata = 0, acc, count;
  logic [1:0] step;
  ssd_ctrl_t ctrl = '0;
  ssd_drive_t drive;
  int n_errors = 0, cmp_count = 0, k;
  ssd_stall_detector i_ssd_stall_detector (.clk(clk), .rst(rst), .ctrl(ctrl), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .cnt_write(cnt_write), .cnt_wdata(cnt_wdata), .cnt_force_load(cnt_force_load),
    .underflow_clear(underflow_clear), .overflow_clear(overflow_clear), .sd_bit(sd_bit),
    .accumulator(acc), .count(count), .step_index(step), .counter_underflow_flag(uf),
    .accumulator_overflow_flag(ov), .drive(drive));
  ssd_coil_model i_ssd_coil_model (.clk(clk), .drive(drive), .emf_pos(emf_pos), .sd_bit(sd_bit));
  initial forever #12.5 clk = ~clk;
  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task wr_cnt(input logic [15:0] v);
    cnt_write = 1;
    cnt_wdata = v;
    tick(1);
    cnt_write = 0;
  endtask : wr_cnt
  task set_mode(input logic [1:0] m);
    ctrl.integrate_select = m[1];
    ctrl.drive_coil_select = m[0];
    tick(3);
  endtask : set_mode
  task step_pulse;
    ctrl.step_advance = 1;
    tick(1);
    ctrl.step_advance = 0;
    tick(3);
  endtask : step_pulse
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  initial
  begin
    #(25 * 20000);
    n_errors++;
    final_report;
  end
  initial
  begin
    tick(8);
    rst = 0;
    `CHK("conv_reset", 1'b1, drive.converter_reset)
    ctrl.converter_power_up = 1;
    ctrl.return_zero_enable = 1;
    wr_cnt(16'h0002);
    `CHK("count_load", 16'h0002, count)
    for (k = 0; k < 700 && count !== 16'h0001; k++) tick(1);
    for (k = 0; k < 700 && count !== 16'h0000; k++) tick(1);
    `CHK("div64", 64, k)
    tick(1);
    `CHK("uf_set", 1'b1, uf)
    underflow_clear = 1;
    tick(1);
    underflow_clear = 0;
    tick(1);
    `CHK("uf_clr", 1'b0, uf)
    ctrl.mc_div_sel = 1;
    wr_cnt(16'h0003);
    for (k = 0; k < 1100 && count !== 16'h0002; k++) tick(1);
    for (k = 0; k < 1100 && count !== 16'h0001; k++) tick(1);
    `CHK("div512", 512, k)
    stop_mode = 1;
    tick(3);
    `CHK("stop_conv", 1'b0, drive.converter_on)
    tick(1100);
    `CHK("stop_cnt", 16'h0001, count)
    stop_mode = 0;
    wait_mode = 1;
    ctrl.wait_powerdown = 1;
    tick(3);
    `CHK("wait_conv", 1'b0, drive.converter_on)
    tick(1100);
    `CHK("wait_cnt", 16'h0001, count)
    wait_mode = 0;
    ctrl.converter_power_up = 0;
    tick(3);
    `CHK("pwr_off", 1'b0, drive.converter_on)
    ctrl.converter_power_up = 1;
    ctrl.mc_div_sel = 0;
    wr_cnt(16'hffff);
    for (k = 0; k < 4; k++)
    begin
      set_mode(k[1:0]);
      `CHK("mode_rst", k < 2, drive.converter_reset)
      if (k < 2) `CHK("sin_recirculate_select", SSD_BR_RECIRCULATE_SELECT, drive.sin_bridge)
      if (k[0] == 0) `CHK("cos_open", SSD_BR_OPEN, drive.cos_bridge)
      else `CHK("cos_drv", 1'b1, drive.cos_bridge inside {SSD_BR_POS, SSD_BR_NEG})
    end
    `CHK("offset", 1'b1, drive.offset_comp)
    `CHK("route", 1'b1, drive.sin_to_converter)
    tick(800);
    `CHK("acc_up", 1'b1, $signed(acc) >= 90 && $signed(acc) <= 100)
    set_mode(2'h0);
    `CHK("acc_zero", 16'h0000, acc)
    ctrl.sample_rate_sel = 3;
    emf_pos = 0;
    set_mode(2'h3);
    tick(640);
    `CHK("acc_dn", 1'b1, $signed(acc) <= -8 && $signed(acc) >= -10)
    `CHK("ov_none", 1'b0, ov)
    ctrl.counter_clockwise = 1;
    for (k = 1; k < 6; k++)
    begin
      step_pulse;
      `CHK("ccw_step", k % 4, step)
      `CHK("cos_route", k[0], drive.cos_to_converter)
      `CHK("step_pol", ((k % 4) > 1) ? SSD_BR_NEG : SSD_BR_POS, k[0] ? drive.sin_bridge : drive.cos_bridge)
    end
    ctrl.counter_clockwise = 0;
    for (k = 0; k < 3; k++)
    begin
      step_pulse;
      `CHK("cw_step", (4 - k) % 4, step)
    end
    final_report;
  end
endmodule : ssd_stall_detector_bench
